// ---- hdl/pdc_div.sv ----
// pulse divider: emits one pulse for every div input ticks
// assumes tick is a one-cycle pulse synchronous to ref_clk
`default_nettype none
module pdc_div (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [13:0] div,
  output logic pulse
);
  typedef struct packed {
    logic [13:0] cnt;
    logic pulse;
  } pdc_div_st_t;

  pdc_div_st_t st_r;
  pdc_div_st_t st_nxt;

  // a zero setting would fire on every tick, so it counts as divide by one
  function automatic logic [13:0] pdc_eff(input logic [13:0] d);
    pdc_eff = (d == 14'h0000) ? pdc_pkg::PDC_DIV_ONE : d;
  endfunction

  // ==========================================================================
  // counter
  always_comb begin
    st_nxt = st_r;
    st_nxt.pulse = 1'b0;
    if (!run) begin
      st_nxt.cnt = 14'h0000;
    end else if (tick) begin
      if (st_r.cnt + 14'h0001 >= pdc_eff(div)) begin
        st_nxt.cnt = 14'h0000;
        st_nxt.pulse = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulse = st_r.pulse;

  // ==========================================================================
  // checks
  // a counted tick leaves the count below the setting it was counted
  // against; a setting that shrinks later is caught by the wrap compare
  a_div_range: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    run && tick |=> st_r.cnt < pdc_eff($past(div)))
    else $error("divider count beyond setting");
  a_div_idle: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    !run |=> !pulse)
    else $error("divider pulsed while stopped");
endmodule
`default_nettype wire

// ---- hdl/pdc_pkg.sv ----
// package for the pll divider configuration register bank
// assumes a single 20 MHz clock domain and word-wide host writes
`default_nettype none
package pdc_pkg;
  // ==========================================================================
  // register addresses on the host word port
  localparam logic [3:0] PDC_ADDR_DIV = 4'hA;
  localparam logic [3:0] PDC_ADDR_CTRL = 4'hB;
  localparam int PDC_REG_W = 28;
  localparam int PDC_DIV_W = 14;
  localparam int PDC_FB_W = 7;
  // ==========================================================================
  // field positions
  localparam int PDC_REF_DIV_LSB = 0;
  localparam int PDC_OSC_DIV_LSB = 14;
  localparam int PDC_FB_COUNT_LSB = 5;
  localparam int PDC_FB_PHASE_LSB = 12;
  localparam int PDC_LOCK_BIT = 26;
  localparam int PDC_STATE_BIT = 27;
  // reset value before the nonvolatile copy lands
  localparam logic [27:0] PDC_RST_WORD = 28'h0000000;
  localparam logic [13:0] PDC_DIV_ONE = 14'h0001;
  localparam logic [13:0] PDC_DIV_TWO = 14'h0002;

  // first register: bit 0 is the reference divider lsb
  typedef struct packed {
    logic [13:0] osc_div;
    logic [13:0] ref_div;
  } pdc_div_t;

  // second register, msb first so bit 0 is the last field
  typedef struct packed {
    logic nvm_state_flag;
    logic nvm_lock_flag;
    logic hold_role;
    logic ref_select_delay;
    logic ref_reshape_ctrl;
    logic diag_feedback_select;
    logic output_source_select;
    logic tree_source_select;
    logic pll_power_off;
    logic [6:0] feedback_phase;
    logic [6:0] feedback_count;
    logic feedback_input_invert;
    logic feedback_clock_type_sel;
    logic feedback_divider_off;
    logic secondary_prescale_half;
    logic primary_prescale_half;
  } pdc_ctrl_t;

  // host write request
  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [27:0] data;
  } pdc_wr_t;
endpackage
`default_nettype wire

// ---- hdl/pdc_regs.sv ----
// configuration register bank of a pll clock synchronizer, with the
// prescale and divider chains that feed the phase comparator
// assumes the serial front end delivers whole 28-bit words on wr, the
// nonvolatile array presents its image on nvm_word10/11, and all clock
// level and tick inputs are already synchronous to ref_clk
//
// Notes on behaviour
// - reference divider in first register bits 0-13
// - oscillator divider in first register bits 14-27
// - bit 0 halves primary reference first
// - bit 1 halves secondary reference first
// - bit 2 set stops the feedback divider
// - bit 3 picks cmos or cml feedback
// - bit 4 inverts feedback divider input clock
// - feedback count bits 5-11, phase 12-18
// - bit 19 set powers the pll down
// - bit 20 picks tree and feedback source
// - bit 21 picks output clock source
// - bit 22 feeds feedback from secondary reference
// - bit 23 set disables reference reshaping
// - bit 24 picks short or long select delay
// - bit 25 makes shared pin hold or reset
// - bits 26-27 report nonvolatile lock and status
// - copy nonvolatile image at power-up and wake
// - compare divided reference against divided feedback
`default_nettype none
module pdc_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pdc_pkg::pdc_wr_t wr,
  input wire logic [3:0] rd_addr,
  output logic [27:0] rd_data,
  input wire logic power_down,
  input wire logic [27:0] nvm_word10,
  input wire logic [27:0] nvm_word11,
  input wire logic nvm_locked,
  input wire logic nvm_status,
  input wire logic ref_sel,
  input wire logic pri_ref_tick,
  input wire logic sec_ref_tick,
  input wire logic primary_oscillator,
  input wire logic aux_clk,
  output pdc_pkg::pdc_div_t cfg_div,
  output pdc_pkg::pdc_ctrl_t cfg_ctrl,
  output logic pfd_up,
  output logic pfd_dn
);
  typedef struct packed {
    pdc_pkg::pdc_div_t div;
    pdc_pkg::pdc_ctrl_t ctrl;
    logic [27:0] rd_data;
    logic load_pend;
    logic pd_q;
    logic tree_q;
    logic up;
    logic dn;
  } pdc_st_t;

  pdc_st_t st_r;
  pdc_st_t st_nxt;

  logic pre_pulse;
  logic ref_pulse;
  logic p_pulse;
  logic fb_pulse;
  logic tree_lvl;
  logic tree_edge;
  logic ref_tick;
  logic fb_in;
  logic [13:0] pre_div;
  logic fb_run;

  // ==========================================================================
  // reference path: pick input, optional halving, then reference divider
  always_comb begin
    ref_tick = ref_sel ? sec_ref_tick : pri_ref_tick;
    if (ref_sel) begin
      pre_div = st_r.ctrl.secondary_prescale_half ? pdc_pkg::PDC_DIV_TWO
                                                  : pdc_pkg::PDC_DIV_ONE;
    end else begin
      pre_div = st_r.ctrl.primary_prescale_half ? pdc_pkg::PDC_DIV_TWO
                                                : pdc_pkg::PDC_DIV_ONE;
    end
  end

  pdc_div u_pre (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(!st_r.ctrl.pll_power_off),
    .tick(ref_tick),
    .div(pre_div),
    .pulse(pre_pulse)
  );

  pdc_div u_mdiv (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(!st_r.ctrl.pll_power_off),
    .tick(pre_pulse),
    .div(st_r.div.ref_div),
    .pulse(ref_pulse)
  );

  // ==========================================================================
  // feedback path: tree source, edge polarity, diagnostic tap, p then n
  always_comb begin
    tree_lvl = st_r.ctrl.tree_source_select ? aux_clk
                                            : primary_oscillator;
    // the inverted mode counts on the falling edge of the tree clock
    if (st_r.ctrl.feedback_input_invert) begin
      tree_edge = st_r.tree_q && !tree_lvl;
    end else begin
      tree_edge = !st_r.tree_q && tree_lvl;
    end
    fb_in = st_r.ctrl.diag_feedback_select ? sec_ref_tick : tree_edge;
    fb_run = !st_r.ctrl.feedback_divider_off &&
             !st_r.ctrl.pll_power_off;
  end

  pdc_div u_pdiv (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(fb_run),
    .tick(fb_in),
    .div({7'h00, st_r.ctrl.feedback_count}),
    .pulse(p_pulse)
  );

  pdc_div u_ndiv (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .run(fb_run),
    .tick(p_pulse),
    .div(st_r.div.osc_div),
    .pulse(fb_pulse)
  );

  // ==========================================================================
  // next state: load, host write, status, read mux, phase compare
  always_comb begin
    st_nxt = st_r;
    st_nxt.pd_q = power_down;
    st_nxt.tree_q = tree_lvl;
    // wake from power-down asks for a fresh copy of the image
    if (st_r.pd_q && !power_down) begin
      st_nxt.load_pend = 1'b1;
    end
    if (st_r.load_pend && !power_down) begin
      // the copy wins over a host write landing in the same cycle
      st_nxt.div = pdc_pkg::pdc_div_t'(nvm_word10);
      st_nxt.ctrl = pdc_pkg::pdc_ctrl_t'(nvm_word11);
      st_nxt.load_pend = 1'b0;
    end else if (wr.en && wr.addr == pdc_pkg::PDC_ADDR_DIV) begin
      st_nxt.div = pdc_pkg::pdc_div_t'(wr.data);
    end else if (wr.en && wr.addr == pdc_pkg::PDC_ADDR_CTRL) begin
      // one write sets every control bit at once
      // including the delay and pin-role bits
      st_nxt.ctrl = pdc_pkg::pdc_ctrl_t'(wr.data);
    end
    // status bits always mirror the array; host data there is dropped
    st_nxt.ctrl.nvm_lock_flag = nvm_locked;
    st_nxt.ctrl.nvm_state_flag = nvm_status;
    // unmapped addresses read back as zero
    unique case (rd_addr)
      pdc_pkg::PDC_ADDR_DIV: st_nxt.rd_data = st_r.div;
      pdc_pkg::PDC_ADDR_CTRL: st_nxt.rd_data = st_r.ctrl;
      default: st_nxt.rd_data = pdc_pkg::PDC_RST_WORD;
    endcase
    // classic up/down pair with common clear when both are set
    if (st_r.ctrl.pll_power_off || (st_r.up && st_r.dn)) begin
      st_nxt.up = 1'b0;
      st_nxt.dn = 1'b0;
    end else begin
      st_nxt.up = st_r.up || ref_pulse;
      st_nxt.dn = st_r.dn || fb_pulse;
    end
  end

  // ==========================================================================
  // state register; the copy is pending from reset so it runs on release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.load_pend <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_div = st_r.div;
  assign cfg_ctrl = st_r.ctrl;
  assign rd_data = st_r.rd_data;
  assign pfd_up = st_r.up;
  assign pfd_dn = st_r.dn;

  // ==========================================================================
  // checks
  // a host word counts only when no image copy takes the same edge
  logic host_div;
  logic host_ctrl;
  assign host_div = wr.en && wr.addr == pdc_pkg::PDC_ADDR_DIV &&
                    !(st_r.load_pend && !power_down);
  assign host_ctrl = wr.en && wr.addr == pdc_pkg::PDC_ADDR_CTRL &&
                     !(st_r.load_pend && !power_down);

  // both divider fields take the host word at their own positions
  a_ref_div_wr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    host_div |=> cfg_div.ref_div == $past(wr.data[13:0]))
    else $error("reference divider not written");

  a_osc_div_wr: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    host_div |=> cfg_div.osc_div == $past(wr.data[27:14]))
    else $error("oscillator divider not written");

  // every writable control field follows the host word
  a_ctrl_fields: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    host_ctrl |=> cfg_ctrl[25:0] == $past(wr.data[25:0]))
    else $error("control fields not written");

  // the status bits ignore host data and mirror the array
  a_lock_ro: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    host_ctrl |=> cfg_ctrl.nvm_lock_flag == $past(nvm_locked))
    else $error("lock bit followed host data");

  a_status_bits: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> cfg_ctrl.nvm_state_flag == $past(nvm_status))
    else $error("status bit does not mirror array");

  // leaving standby reloads the image two edges later
  a_wake_copy: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    $fell(power_down) ##1 !power_down |=> cfg_div == $past(nvm_word10))
    else $error("image not copied on wake");

  // flags clear together, stay quiet in power-down and follow pulses
  a_pfd_clear: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    pfd_up && pfd_dn |=> !pfd_up && !pfd_dn)
    else $error("phase flags not cleared together");

  a_pd_quiet: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    cfg_ctrl.pll_power_off [*2] |-> !pfd_up && !pfd_dn)
    else $error("phase flags active while powered down");

  a_up_on_ref: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    ref_pulse && !cfg_ctrl.pll_power_off && !(pfd_up && pfd_dn) |=> pfd_up)
    else $error("reference pulse did not raise up flag");

  a_dn_on_fb: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    fb_pulse && !cfg_ctrl.pll_power_off && !(pfd_up && pfd_dn) |=> pfd_dn)
    else $error("feedback pulse did not raise down flag");

  // feedback chain: halted when off, diagnostic tap counts secondary ticks
  a_fb_off: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    cfg_ctrl.feedback_divider_off [*3] |-> !fb_pulse)
    else $error("feedback pulses while divider off");

  a_diag_tap: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    cfg_ctrl.diag_feedback_select && fb_run && sec_ref_tick &&
    cfg_ctrl.feedback_count < 7'h02 |=> p_pulse)
    else $error("secondary tick not counted on diagnostic tap");

  // read data answers one edge after the address is sampled
  a_rd_div: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_addr == pdc_pkg::PDC_ADDR_DIV |=> rd_data == $past(st_r.div))
    else $error("read of first register wrong");

  a_rd_ctrl: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_addr == pdc_pkg::PDC_ADDR_CTRL |=> rd_data == $past(st_r.ctrl))
    else $error("read of second register wrong");

  // unmapped addresses read as zero so stray reads never alias a register
  a_rd_unmapped: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    rd_addr != pdc_pkg::PDC_ADDR_DIV && rd_addr != pdc_pkg::PDC_ADDR_CTRL
    |=> rd_data == pdc_pkg::PDC_RST_WORD)
    else $error("unmapped read not zero");

  // main scenarios: control write, wake, both flags, down alone, tap
  c_host_ctrl: cover property (@(posedge ref_clk) disable iff (!arst_n)
    host_ctrl);
  c_wake: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(power_down));
  c_pfd_both: cover property (@(posedge ref_clk) disable iff (!arst_n)
    pfd_up && pfd_dn);
  c_dn_alone: cover property (@(posedge ref_clk) disable iff (!arst_n)
    pfd_dn && !pfd_up);
  c_diag_tap: cover property (@(posedge ref_clk) disable iff (!arst_n)
    cfg_ctrl.diag_feedback_select && p_pulse);
endmodule
`default_nettype wire

// ---- test/pdc_host.sv ----
// host model: sends whole-word register writes on the word port
// assumes the block samples wr on rising ref_clk edges
`default_nettype none
module pdc_host (
  input wire logic ref_clk,
  output var pdc_pkg::pdc_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // write task
  // idle data is the inverse of the last word, so stale data never matches
  initial wr = '0;
  task automatic write(input logic [3:0] a, input logic [27:0] d);
    @(negedge ref_clk);
    wr = '{en: 1'b1, addr: a, data: d}; // one whole word per cycle
    @(negedge ref_clk);
    wr = '{en: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire

// ---- test/test_pdc_regs.sv ----
// self-checking bench for the pll divider configuration registers
// assumes pdc_regs and pdc_pkg are compiled first
`default_nettype none
module test_pdc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [27:0] W10 = 28'hABCDE12;
  localparam logic [27:0] W11 = 28'h5A5A5A5;
  localparam logic [3:0] A_DIV = pdc_pkg::PDC_ADDR_DIV;
  localparam logic [3:0] A_CTL = pdc_pkg::PDC_ADDR_CTRL;
  logic ref_clk, arst_n, power_down, lk, st, pri_tick, pfd_up, pfd_dn;
  logic osc, aux, sec_tick, rsel;
  logic [3:0] rd_addr;
  logic [27:0] rd_data;
  pdc_pkg::pdc_wr_t wr;
  pdc_pkg::pdc_div_t cfg_div;
  pdc_pkg::pdc_ctrl_t cfg_ctrl;
  int n_errors = 0;
  int comparisons = 0;
  // ==========================================================================
  // clock, host and device
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;
  pdc_host i_pdc_host (.ref_clk(ref_clk), .wr(wr));
  // oscillator levels and reference ticks come from the test sequence
  pdc_regs i_pdc_regs (.ref_clk(ref_clk), .arst_n(arst_n), .wr(wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .power_down(power_down),
    .nvm_word10(W10), .nvm_word11(W11), .nvm_locked(lk), .nvm_status(st),
    .ref_sel(rsel), .pri_ref_tick(pri_tick), .sec_ref_tick(sec_tick),
    .primary_oscillator(osc), .aux_clk(aux), .cfg_div(cfg_div),
    .cfg_ctrl(cfg_ctrl), .pfd_up(pfd_up), .pfd_dn(pfd_dn));
  // ==========================================================================
  // compare, read and closing tasks
  task automatic chk(input string nm, input logic [27:0] e,
                     input logic [27:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // rd_data answers one edge after rd_addr is sampled
  task automatic rd(input logic [3:0] a, input logic [27:0] e,
                    input string nm);
    @(negedge ref_clk);
    rd_addr = a;
    @(negedge ref_clk);
    chk(nm, e, rd_data);
  endtask
  // one reference tick, primary or secondary, for a single cycle
  task automatic tick(input logic sec);
    @(negedge ref_clk);
    if (sec) begin
      sec_tick = 1'b1;
    end else begin
      pri_tick = 1'b1;
    end
    @(negedge ref_clk);
    sec_tick = 1'b0;
    pri_tick = 1'b0;
  endtask
  // each divider adds one edge, so a flag change shows within a few cycles
  task automatic wait_pfd(input logic [1:0] e, input string nm);
    for (int k = 0; k < 8 && {pfd_up, pfd_dn} !== e; k++) begin
      @(negedge ref_clk);
    end
    chk(nm, 28'(e), 28'({pfd_up, pfd_dn}));
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // watchdog: the tests need well under 400 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
  // ==========================================================================
  // test sequence
  initial begin
    arst_n = 1'b0;
    power_down = 1'b0;
    lk = 1'b1;
    st = 1'b0;
    pri_tick = 1'b0;
    sec_tick = 1'b0;
    osc = 1'b0;
    aux = 1'b0;
    rsel = 1'b0;
    rd_addr = 4'h0;
    repeat (20) @(negedge ref_clk);
    chk("div in reset", 28'h0, cfg_div);
    chk("ctrl in reset", 28'h0, cfg_ctrl);
    arst_n = 1'b1;
    @(negedge ref_clk);
    chk("div image", W10, cfg_div);
    chk("ctrl image", {st, lk, W11[25:0]}, cfg_ctrl);
    $display("test image done");
    i_pdc_host.write(A_DIV, {14'h2ACE, 14'h1357});
    chk("ref div", 28'(14'h1357), 28'(cfg_div.ref_div));
    chk("osc div", 28'(14'h2ACE), 28'(cfg_div.osc_div));
    rd(A_DIV, {14'h2ACE, 14'h1357}, "read div");
    $display("test dividers done");
    // walking one across every writable control bit
    for (int i = 0; i < 26; i++) begin
      i_pdc_host.write(A_CTL, 28'h1 << i);
      chk("ctrl word", {st, lk, 26'h1 << i}, cfg_ctrl);
      chk("ctrl bit", 28'h1, 28'(cfg_ctrl[i]));
      rd(A_CTL, {st, lk, 26'h1 << i}, "read ctrl");
    end
    i_pdc_host.write(A_CTL, (28'(7'h2A) << 12) | (28'(7'h55) << 5));
    chk("fb count", 28'h55, 28'(cfg_ctrl.feedback_count));
    chk("fb phase", 28'h2A, 28'(cfg_ctrl.feedback_phase));
    $display("test control bits done");
    // status bits are read only and follow the array
    i_pdc_host.write(A_CTL, 28'hFFFFFFF);
    chk("lock kept", {st, lk, 26'h3FFFFFF}, cfg_ctrl);
    lk = 1'b0;
    @(negedge ref_clk);
    chk("lock follows", 28'h3FFFFFF, cfg_ctrl);
    i_pdc_host.write(4'h3, 28'h1234567);
    rd(4'h3, 28'h0, "read unmapped");
    rd(A_DIV, {14'h2ACE, 14'h1357}, "div kept");
    rd(A_CTL, 28'h3FFFFFF, "ctrl kept");
    $display("test status and unmapped done");
    // wake from standby copies the image again
    @(negedge ref_clk);
    power_down = 1'b1;
    repeat (2) @(negedge ref_clk);
    power_down = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("div wake", W10, cfg_div);
    chk("ctrl wake", {st, lk, W11[25:0]}, cfg_ctrl);
    $display("test wake done");
    // reference path with both dividers at one raises the up flag
    i_pdc_host.write(A_CTL, 28'h0);
    i_pdc_host.write(A_DIV, {14'h0001, 14'h0001});
    pri_tick = 1'b1;
    @(negedge ref_clk);
    pri_tick = 1'b0;
    for (int k = 0; k < 8 && pfd_up !== 1'b1; k++) @(negedge ref_clk);
    chk("up flag", 28'h1, 28'(pfd_up));
    chk("down flag", 28'h0, 28'(pfd_dn));
    $display("test phase path done");
    // rising primary edge through p and n meets the up flag: both clear
    osc = 1'b1;
    wait_pfd(2'b11, "flags both");
    @(negedge ref_clk);
    chk("flags cleared", 28'h0, 28'({pfd_up, pfd_dn}));
    // inverted mode counts the falling edge
    i_pdc_host.write(A_CTL, 28'h0000010);
    osc = 1'b0;
    wait_pfd(2'b01, "falling edge");
    $display("test feedback edges done");
    // primary halving: one tick is swallowed, the second reaches m
    i_pdc_host.write(A_CTL, 28'h0000001);
    tick(1'b0);
    repeat (4) @(negedge ref_clk);
    chk("half holds", 28'h1, 28'({pfd_up, pfd_dn}));
    tick(1'b0);
    wait_pfd(2'b11, "half passes");
    // secondary halving with the diagnostic tap: first tick reaches n only
    i_pdc_host.write(A_CTL, 28'h0400002);
    rsel = 1'b1;
    tick(1'b1);
    wait_pfd(2'b01, "diag tap");
    tick(1'b1);
    wait_pfd(2'b11, "secondary half");
    $display("test prescale and tap done");
    // feedback divider off: a secondary tick on the tap sets nothing
    i_pdc_host.write(A_CTL, 28'h0400004);
    rsel = 1'b0;
    tick(1'b1);
    repeat (4) @(negedge ref_clk);
    chk("fb off", 28'h0, 28'({pfd_up, pfd_dn}));
    // auxiliary clock as tree source: its rising edge sets down
    i_pdc_host.write(A_CTL, 28'h0100000);
    aux = 1'b1;
    wait_pfd(2'b01, "aux tree");
    // power-down clears the flags
    i_pdc_host.write(A_CTL, 28'h0080000);
    wait_pfd(2'b00, "pd clears");
    $display("test feedback controls done");
    end_sim();
  end
endmodule
`default_nettype wire
